/* File: ucb_defs.svh */
`ifndef UCB_DEFS_SVH
`define UCB_DEFS_SVH

// register offsets on the 3-bit register port
`define UCB_OFF_LC1 3'h0
`define UCB_OFF_LC2 3'h1
`define UCB_OFF_DATA 3'h2
`define UCB_OFF_BRDH 3'h3
`define UCB_OFF_BRDL 3'h4
`define UCB_OFF_MODC 3'h5
`define UCB_OFF_STAT 3'h6

// line_control_one field positions
`define UCB_LC1_PORT_EN 7
`define UCB_LC1_WLEN 6
`define UCB_LC1_PAR_EN 5
`define UCB_LC1_PTYPE_HI 4
`define UCB_LC1_PTYPE_LO 3
`define UCB_LC1_BREAK 2
`define UCB_LC1_RX9 1
`define UCB_LC1_TX9 0

// line_control_two field positions
`define UCB_LC2_TXEN 7
`define UCB_LC2_RXEN 6
`define UCB_LC2_STOPS 5
`define UCB_LC2_ADDEN 4
`define UCB_LC2_WAKE 3
`define UCB_LC2_RIE 2
`define UCB_LC2_TIIE 1
`define UCB_LC2_TEIE 0

// modulation control field positions
`define UCB_MOD_HI 5
`define UCB_MOD_LO 3
`define UCB_MOD_RANGE 2

// reset values
`define UCB_LC2_RST 8'h00
`define UCB_BRD_RST 16'h0000
`define UCB_MOD_RST 3'h0

// parity type codes
`define UCB_PAR_EVEN 2'h0
`define UCB_PAR_ODD 2'h1
`define UCB_PAR_MARK 2'h2
`define UCB_PAR_SPACE 2'h3

// frame constants, in bit times
`define UCB_BREAK_BITS 4'hD
`define UCB_BITS_8 4'h8
`define UCB_BITS_9 4'h9

`endif

/* File: ucb_pkg.sv */
package ucb_pkg;

    // transmitter states, gray along start, data, parity, stop
    typedef enum logic [2:0] {
        UCB_TX_IDLE = 3'h0,
        UCB_TX_START = 3'h1,
        UCB_TX_DATA = 3'h3,
        UCB_TX_PAR = 3'h2,
        UCB_TX_STOP = 3'h6,
        UCB_TX_BRK = 3'h7,
        UCB_TX_BREL = 3'h5
    } ucb_tx_state_t;

    // receiver states
    typedef enum logic [1:0] {
        UCB_RX_IDLE = 2'h0,
        UCB_RX_START = 2'h1,
        UCB_RX_DATA = 2'h3,
        UCB_RX_STOP = 2'h2
    } ucb_rx_state_t;

    // line_control_one, software-written part
    typedef struct packed {
        logic port_en;
        logic word_length_sel;
        logic par_en;
        logic [1:0] parity_type_sel;
        logic send_break;
        logic tx_ninth_bit;
    } ucb_lc1_t;

    // one received word as it leaves the deserialiser
    typedef struct packed {
        logic ninth;
        logic [7:0] data;
    } ucb_word_t;

endpackage

/* File: ucb_uart.sv */
`timescale 1ns/1ns
// Behaviour
// RULE1 - parity type 00 even, 01 odd, 10 forced one, 11 forced zero
// RULE2 - break waits for buffered data, then holds line low 13+ bits
// RULE3 - in 9-bit mode the ninth received bit goes to rx_ninth_bit
// RULE4 - in 9-bit mode the ninth sent bit comes from tx_ninth_bit
// RULE5 - transmit enable low: transmitter off, aborted, buffers reset, pin floats
// RULE6 - transmitter runs and drives pin only with both enables set
// RULE7 - clearing transmit enable mid-character aborts and floats the pin
// RULE8 - receive enable low: receiver off, aborted, buffers reset
// RULE9 - receiver runs only with receive and port enables both set
// RULE10 - one stop bit when stop select is zero, two when one
// RULE11 - address detect: words with address bit set are kept and flagged
// RULE12 - address detect: words with address bit clear are dropped silently
// RULE13 - wake enable, clock stopped: receive falling edge raises wake request
// RULE14 - no wake while clock runs or with wake enable clear
// RULE15 - receive enable gates overrun and data-available onto the request
// RULE16 - idle enable gates transmitter idle onto the request
// RULE17 - empty enable gates transmit-empty onto the request
// RULE18 - one data location: writes send, reads return received character
// RULE19 - bit rate is clock over divider plus modulation eighths
// RULE20 - software keeps divider at least 16, or 8 with range select
// RULE21 - software writes divider low byte before high byte
// RULE22 - modulation accumulates per bit; carry adds one clock to that bit
// RULE23 - with parity on, top data position is parity, not stored
// RULE24 - port disable empties buffers, resets counters, enables, break, flags
// RULE25 - after break clears, line returns high before next character
module ucb_uart
    import ucb_pkg::*;
(
    input wire logic SYS_CLK, // 125 MHz port clock
    input wire logic RST_N, // async reset, active low
    input wire logic [2:0] ADDR, // register address
    input wire logic [7:0] WDATA, // write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    output logic [7:0] RDATA, // read data, cycle after RD
    input wire logic RX_PIN, // receive pin, asynchronous
    input wire logic PORT_CLK_ON, // high while port clock runs
    output logic TX_O, // transmit pin level
    output logic TX_OE, // transmit pin enable
    output logic IRQ_REQ, // port interrupt request, level
    output logic WAKE_REQ // receive-pin wake request, level
);
`include "ucb_defs.svh"

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    ucb_lc1_t lc1_q;
    logic [7:0] lc2_q;
    logic [15:0] brd_q;
    logic [7:0] brd_lo_q;
    logic [2:0] fmod_q;
    logic range_q;
    logic [7:0] rdata_q;
    logic stat_seen_q;
    logic rxs1_q, rxs2_q, rxs3_q;
    logic clk1_q, clk2_q;
    logic wake_q;
    ucb_tx_state_t tx_st_q;
    logic [7:0] tx_hold_q;
    logic tx_full_q;
    logic [8:0] tx_sh_q;
    logic tx_par_q;
    logic [3:0] tx_bitn_q;
    logic tx_line_q;
    ucb_rx_state_t rx_st_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_bitn_q;
    ucb_word_t rx_word_q;
    logic rx_full_q;
    logic ovr_q;
    logic [1:0] run, restart, tick, mid;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire tx_on = lc1_q.port_en & lc2_q[`UCB_LC2_TXEN]; // [RULE6]
    wire rx_on = lc1_q.port_en & lc2_q[`UCB_LC2_RXEN]; // [RULE9]
    wire wr_lc1 = WR & (ADDR == `UCB_OFF_LC1);
    wire wr_lc2 = WR & (ADDR == `UCB_OFF_LC2);
    wire wr_data = WR & (ADDR == `UCB_OFF_DATA);
    wire wr_brdh = WR & (ADDR == `UCB_OFF_BRDH);
    wire wr_brdl = WR & (ADDR == `UCB_OFF_BRDL);
    wire wr_modc = WR & (ADDR == `UCB_OFF_MODC);
    wire rd_data = RD & (ADDR == `UCB_OFF_DATA);
    wire rd_stat = RD & (ADDR == `UCB_OFF_STAT);
    wire port_off = wr_lc1 & ~WDATA[`UCB_LC1_PORT_EN];
    wire rx_fall = rxs3_q & ~rxs2_q;
    wire tx_idle = ~tx_on | ((tx_st_q == UCB_TX_IDLE) & ~tx_full_q);
    wire tx_empty = ~tx_full_q;
    wire rx_idle = (rx_st_q == UCB_RX_IDLE);

    // frame widths: data positions, parity replaces the top one
    wire [3:0] nbits = lc1_q.word_length_sel ? `UCB_BITS_9 : `UCB_BITS_8;
    wire [3:0] tx_nd = nbits - {3'h0, lc1_q.par_en}; // [RULE23]

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    // a write clearing the port enable also drops the unit enables
    // and the break request; other settings survive for re-enable
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            lc1_q <= '0;
            lc2_q <= `UCB_LC2_RST;
            brd_q <= `UCB_BRD_RST;
            brd_lo_q <= 8'h00;
            fmod_q <= `UCB_MOD_RST;
            range_q <= 1'b0;
        end else begin
            if (wr_lc1) begin
                lc1_q <= {WDATA[7:3], WDATA[2] & WDATA[7], WDATA[0]}; // [RULE24]
            end
            if (port_off) begin
                lc2_q[`UCB_LC2_TXEN] <= 1'b0; // [RULE24]
                lc2_q[`UCB_LC2_RXEN] <= 1'b0;
            end else if (wr_lc2) begin
                lc2_q <= WDATA;
            end
            if (wr_brdl) begin
                brd_lo_q <= WDATA;
            end
            // high byte write commits both halves together
            if (wr_brdh) begin
                brd_q <= {WDATA, brd_lo_q}; // [RULE21]
            end
            if (wr_modc) begin
                fmod_q <= WDATA[`UCB_MOD_HI:`UCB_MOD_LO];
                range_q <= WDATA[`UCB_MOD_RANGE];
            end
        end
    end

    // read mux; the ninth transmit bit is write-only and reads zero
    wire [7:0] stat_v = {3'h0, ovr_q, rx_idle, rx_full_q, tx_idle, tx_empty};
    wire [7:0] lc1_rd = {lc1_q.port_en, lc1_q.word_length_sel, lc1_q.par_en,
                         lc1_q.parity_type_sel, lc1_q.send_break,
                         rx_word_q.ninth, 1'b0}; // [RULE3]
    wire [7:0] rd_mux =
        (ADDR == `UCB_OFF_LC1) ? lc1_rd :
        (ADDR == `UCB_OFF_LC2) ? lc2_q :
        (ADDR == `UCB_OFF_DATA) ? rx_word_q.data : // [RULE18]
        (ADDR == `UCB_OFF_BRDH) ? brd_q[15:8] :
        (ADDR == `UCB_OFF_BRDL) ? brd_lo_q :
        (ADDR == `UCB_OFF_MODC) ? {2'h0, fmod_q, range_q, 2'h0} :
        (ADDR == `UCB_OFF_STAT) ? stat_v : 8'h00;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 8'h00;
            stat_seen_q <= 1'b0;
        end else begin
            rdata_q <= RD ? rd_mux : 8'h00;
            if (rd_stat) begin
                stat_seen_q <= 1'b1;
            end else if (rd_data | wr_data) begin
                stat_seen_q <= 1'b0;
            end
        end
    end
    assign RDATA = rdata_q;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rxs1_q <= 1'b1;
            rxs2_q <= 1'b1;
            rxs3_q <= 1'b1;
            clk1_q <= 1'b0;
            clk2_q <= 1'b0;
        end else begin
            rxs1_q <= RX_PIN;
            rxs2_q <= rxs1_q;
            rxs3_q <= rxs2_q;
            clk1_q <= PORT_CLK_ON;
            clk2_q <= clk1_q;
        end
    end

    // ----------------------------------------------------------------
    // bit timers: channel 0 transmit, channel 1 receive
    // ----------------------------------------------------------------
    // each timer restarts at frame start so its modulation pattern
    // lines up with the start bit, as the far end expects
    assign run = {rx_on & clk2_q & ~rx_idle, tx_on & clk2_q};
    genvar g;
    for (g = 0; g < 2; g++) begin : g_tmr
        logic [16:0] cnt_q;
        logic [2:0] acc_q;
        logic ext_q;
        logic [3:0] sum;
        logic [16:0] last;
        assign sum = {1'b0, acc_q} + {1'b0, fmod_q}; // [RULE22]
        assign last = {1'b0, brd_q} + {16'h0000, ext_q} - 17'h00001; // [RULE19]
        assign tick[g] = run[g] & (cnt_q == last);
        assign mid[g] = run[g] & (cnt_q == {2'h0, brd_q[15:1]});
        always_ff @(posedge SYS_CLK or negedge RST_N) begin
            if (!RST_N) begin
                cnt_q <= 17'h00000;
                acc_q <= 3'h0;
                ext_q <= 1'b0;
            end else if (!run[g] || restart[g]) begin
                cnt_q <= 17'h00000; // [RULE24]
                acc_q <= fmod_q; // first bit: 0 + mod never carries
                ext_q <= 1'b0;
            end else if (tick[g]) begin
                cnt_q <= 17'h00000;
                acc_q <= sum[2:0];
                ext_q <= sum[3]; // [RULE22]
            end else begin
                cnt_q <= cnt_q + 17'h00001;
            end
        end
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    wire [8:0] tx_word = {lc1_q.tx_ninth_bit, tx_hold_q}; // [RULE4]
    wire [8:0] tx_mask = 9'h1FF >> (4'h9 - tx_nd);
    wire tx_xor = ^(tx_word & tx_mask);
    wire tx_par =
        (lc1_q.parity_type_sel == `UCB_PAR_EVEN) ? tx_xor :
        (lc1_q.parity_type_sel == `UCB_PAR_ODD) ? ~tx_xor :
        (lc1_q.parity_type_sel == `UCB_PAR_MARK); // [RULE1]
    wire tx_load = (tx_st_q == UCB_TX_IDLE) & tx_full_q;
    wire tx_brk_go = (tx_st_q == UCB_TX_IDLE) & ~tx_full_q
                     & lc1_q.send_break; // [RULE2]
    assign restart[0] = tx_load | tx_brk_go;

    // line level per state, registered before the pin
    logic tx_line_d;
    always_comb begin
        case (tx_st_q)
            UCB_TX_START: tx_line_d = 1'b0;
            UCB_TX_DATA: tx_line_d = tx_sh_q[0];
            UCB_TX_PAR: tx_line_d = tx_par_q;
            UCB_TX_BRK: tx_line_d = 1'b0; // [RULE2]
            default: tx_line_d = 1'b1;
        endcase
    end

    // disabling the transmitter mid-frame just drops the frame;
    // the far end sees the pin float, which it must tolerate
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_st_q <= UCB_TX_IDLE;
            tx_hold_q <= 8'h00;
            tx_full_q <= 1'b0;
            tx_sh_q <= 9'h000;
            tx_par_q <= 1'b0;
            tx_bitn_q <= 4'h0;
            tx_line_q <= 1'b1;
        end else if (!tx_on) begin
            tx_st_q <= UCB_TX_IDLE; // [RULE5] [RULE7]
            tx_full_q <= 1'b0;
            tx_bitn_q <= 4'h0;
            tx_line_q <= 1'b1;
        end else begin
            tx_line_q <= tx_line_d;
            if (wr_data) begin
                tx_hold_q <= WDATA; // [RULE18]
                tx_full_q <= 1'b1;
            end else if (tx_load) begin
                tx_full_q <= 1'b0;
            end
            case (tx_st_q)
                UCB_TX_IDLE: begin
                    tx_bitn_q <= 4'h0;
                    if (tx_load) begin
                        tx_sh_q <= tx_word;
                        tx_par_q <= tx_par; // [RULE1]
                        tx_st_q <= UCB_TX_START;
                    end else if (tx_brk_go) begin
                        tx_st_q <= UCB_TX_BRK;
                    end
                end
                UCB_TX_START: begin
                    if (tick[0]) begin
                        tx_st_q <= UCB_TX_DATA;
                    end
                end
                UCB_TX_DATA: begin
                    if (tick[0]) begin
                        tx_sh_q <= {1'b0, tx_sh_q[8:1]};
                        if (tx_bitn_q == tx_nd - 4'h1) begin
                            tx_bitn_q <= 4'h0;
                            tx_st_q <= lc1_q.par_en ? UCB_TX_PAR
                                                    : UCB_TX_STOP;
                        end else begin
                            tx_bitn_q <= tx_bitn_q + 4'h1;
                        end
                    end
                end
                UCB_TX_PAR: begin
                    if (tick[0]) begin
                        tx_st_q <= UCB_TX_STOP; // [RULE23]
                    end
                end
                UCB_TX_STOP: begin
                    if (tick[0]) begin
                        if (tx_bitn_q[0] == lc2_q[`UCB_LC2_STOPS]) begin
                            tx_st_q <= UCB_TX_IDLE; // [RULE10]
                            tx_bitn_q <= 4'h0;
                        end else begin
                            tx_bitn_q <= 4'h1;
                        end
                    end
                end
                UCB_TX_BRK: begin
                    if (tick[0] && tx_bitn_q != `UCB_BREAK_BITS) begin
                        tx_bitn_q <= tx_bitn_q + 4'h1;
                    end
                    if (tx_bitn_q == `UCB_BREAK_BITS && !lc1_q.send_break) begin
                        tx_st_q <= UCB_TX_BREL; // [RULE2]
                    end
                end
                UCB_TX_BREL: begin
                    if (tick[0]) begin
                        tx_st_q <= UCB_TX_IDLE; // [RULE25]
                    end
                end
                default: tx_st_q <= UCB_TX_IDLE;
            endcase
        end
    end
    assign TX_O = tx_line_q;
    assign TX_OE = tx_on; // [RULE6]

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    // eight-bit words land in the top of the shifter, so realign
    wire [8:0] rx_w9 = lc1_q.word_length_sel ? rx_sh_q
                                             : {1'b0, rx_sh_q[8:1]};
    wire rx_addr_bit = lc1_q.word_length_sel ? rx_w9[8] : rx_w9[7];
    wire rx_keep = ~lc2_q[`UCB_LC2_ADDEN] | rx_addr_bit; // [RULE11] [RULE12]
    ucb_word_t rx_new;
    assign rx_new.ninth = rx_w9[8] & ~lc1_q.par_en; // [RULE3] [RULE23]
    assign rx_new.data = {rx_w9[7] &
                          ~(lc1_q.par_en & ~lc1_q.word_length_sel),
                          rx_w9[6:0]}; // [RULE23]
    wire rx_done = (rx_st_q == UCB_RX_STOP) & mid[1];
    assign restart[1] = (rx_st_q == UCB_RX_IDLE) & rx_fall;

    // overrun keeps the old word; set beats a same-cycle clear
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_st_q <= UCB_RX_IDLE;
            rx_sh_q <= 9'h000;
            rx_bitn_q <= 4'h0;
            rx_word_q <= '0;
            rx_full_q <= 1'b0;
            ovr_q <= 1'b0;
        end else if (!rx_on) begin
            rx_st_q <= UCB_RX_IDLE; // [RULE8] [RULE24]
            rx_bitn_q <= 4'h0;
            rx_full_q <= 1'b0;
            ovr_q <= 1'b0;
        end else begin
            if (rd_data) begin
                rx_full_q <= 1'b0;
                if (stat_seen_q) begin
                    ovr_q <= 1'b0;
                end
            end
            if (rx_done && rx_keep) begin
                if (rx_full_q && !rd_data) begin
                    ovr_q <= 1'b1;
                end else begin
                    rx_word_q <= rx_new;
                    rx_full_q <= 1'b1;
                end
            end
            case (rx_st_q)
                UCB_RX_IDLE: begin
                    rx_bitn_q <= 4'h0;
                    if (rx_fall && clk2_q) begin
                        rx_st_q <= UCB_RX_START; // [RULE9]
                    end
                end
                UCB_RX_START: begin
                    if (mid[1]) begin
                        rx_st_q <= rxs2_q ? UCB_RX_IDLE : UCB_RX_DATA;
                    end
                end
                UCB_RX_DATA: begin
                    if (mid[1]) begin
                        rx_sh_q <= {rxs2_q, rx_sh_q[8:1]};
                        if (rx_bitn_q == nbits - 4'h1) begin
                            rx_st_q <= UCB_RX_STOP;
                        end else begin
                            rx_bitn_q <= rx_bitn_q + 4'h1;
                        end
                    end
                end
                UCB_RX_STOP: begin
                    if (mid[1]) begin
                        rx_st_q <= UCB_RX_IDLE;
                    end
                end
                default: rx_st_q <= UCB_RX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // wake request and interrupt request
    // ----------------------------------------------------------------
    // the wake detector only matters while the port clock is off;
    // it drops once software has the clock running again
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            wake_q <= 1'b0;
        end else if (clk2_q) begin
            wake_q <= 1'b0; // [RULE14]
        end else if (rx_fall && lc2_q[`UCB_LC2_WAKE] && lc1_q.port_en) begin
            wake_q <= 1'b1; // [RULE13]
        end
    end
    assign WAKE_REQ = wake_q;

    wire irq_rx = lc2_q[`UCB_LC2_RIE] & (ovr_q | rx_full_q); // [RULE15]
    wire irq_ti = lc2_q[`UCB_LC2_TIIE] & tx_idle; // [RULE16]
    wire irq_te = lc2_q[`UCB_LC2_TEIE] & tx_empty; // [RULE17]
    assign IRQ_REQ = irq_rx | irq_ti | irq_te | wake_q;

endmodule

/* File: ucb_uart_chk.sv */
`timescale 1ns/1ns
`include "ucb_defs.svh"
module ucb_uart_chk (
    input wire logic SYS_CLK, // clock
    input wire logic RST_N, // reset
    input wire logic [2:0] ADDR, // address
    input wire logic [7:0] WDATA, // write data
    input wire logic WR, // write
    input wire logic RD, // read
    input wire logic [7:0] RDATA, // read data
    input wire logic PORT_CLK_ON, // clock on
    input wire logic TX_O, // line
    input wire logic TX_OE, // line enable
    input wire logic IRQ_REQ, // request
    input wire logic WAKE_REQ // wake
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    logic pen_q, ten_q, wk_q, tx_q;
    logic [2:0] ie_q, on_q;
    logic [7:0] lo_q;
    logic [15:0] brd_q, run_q;
    wire w1 = WR && ADDR == `UCB_OFF_LC1;
    wire w2 = WR && ADDR == `UCB_OFF_LC2;
    // shadows of enables and divider, plus line run length
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {pen_q, ten_q, wk_q, ie_q, lo_q, brd_q} <= '0;
            {tx_q, run_q, on_q} <= {1'b1, 19'h0};
        end else begin
            if (w1) pen_q <= WDATA[7];
            if (w1 && !WDATA[7] || w2) ten_q <= w2 && WDATA[7];
            if (w2) {wk_q, ie_q} <= WDATA[3:0];
            if (WR && ADDR == `UCB_OFF_BRDL) lo_q <= WDATA;
            if (WR && ADDR == `UCB_OFF_BRDH) brd_q <= {WDATA, lo_q};
            tx_q <= TX_O;
            run_q <= TX_O != tx_q ? 16'h1 : run_q + 16'(~&run_q);
            on_q <= PORT_CLK_ON ? on_q + 3'(~&on_q) : 3'h0;
        end
    end
    property p_rd; !$past(RD) |-> RDATA == 8'h00; endproperty
    a_rd: assert property (p_rd)
        else $error("read data out of slot");
    property p_oe; TX_OE == (pen_q && ten_q); endproperty
    a_oe: assert property (p_oe)
        else $error("line enable wrong");
    property p_rel; $fell(TX_OE) |-> ##[0:2] TX_O; endproperty
    a_rel: assert property (p_rel)
        else $error("line not idle on release");
    property p_off; !TX_OE [*3] |-> TX_O; endproperty
    a_off: assert property (p_off)
        else $error("disabled line low");
    property p_bit; $rose(TX_O) && TX_OE && $past(TX_OE) |->
        run_q >= brd_q; endproperty
    a_bit: assert property (p_bit)
        else $error("bit shorter than divider");
    property p_wk; $rose(WAKE_REQ) |-> wk_q && on_q < 3'h5; endproperty
    a_wk: assert property (p_wk)
        else $error("wake not allowed");
    property p_irq; ie_q == 3'h0 && !WAKE_REQ |-> !IRQ_REQ; endproperty
    a_irq: assert property (p_irq)
        else $error("request while all gated");
    property p_dis; w1 && !WDATA[7] && ie_q[0] |-> ##[1:2] IRQ_REQ;
    endproperty
    a_dis: assert property (p_dis)
        else $error("no empty request after disable");
    c_wk: cover property ($rose(WAKE_REQ));
    c_brk: cover property ($rose(TX_O) && run_q > 16'd200);
    c_irq: cover property ($rose(IRQ_REQ));
endmodule

/* File: ucb_remote.sv */
`timescale 1ns/1ns
module ucb_remote (
    input wire logic clk, // port clock
    input wire logic tx_line, // line from block
    output logic rx_line // line into block
);
    // idles high, as a pulled-up line would
    initial rx_line = 1'b1;
    // start low, bits lsb first, then two bit times idle
    task automatic send(input logic [8:0] w, input int n, input int b);
        rx_line <= 1'b0;
        repeat (b) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rx_line <= w[i];
            repeat (b) @(posedge clk);
        end
        rx_line <= 1'b1;
        repeat (2 * b) @(posedge clk);
    endtask
    // sample mid-bit; the caller has already seen the start edge
    task automatic recv(input int n, input int b, output logic [8:0] w);
        w = '0;
        repeat (b / 2) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            repeat (b) @(posedge clk);
            w[i] = tx_line;
        end
    endtask
endmodule

/* File: ucb_uart_bench.sv */
`timescale 1ns/1ns
`include "ucb_defs.svh"
module ucb_uart_bench;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, con = 1'b1;
    logic [2:0] ad = 3'h0;
    logic [7:0] wd = 8'h00, rdata;
    logic [8:0] w;
    logic txo, oe, irq, wake, rx;
    int fail_count = 0, total_checks = 0, n, m;
    // 8 ns clock
    always #4 clk = ~clk;
    ucb_uart i_dut (.SYS_CLK(clk), .RST_N(rst_n), .ADDR(ad), .WDATA(wd),
        .WR(wr), .RD(rd), .RDATA(rdata), .RX_PIN(rx), .PORT_CLK_ON(con),
        .TX_O(txo), .TX_OE(oe), .IRQ_REQ(irq), .WAKE_REQ(wake));
    ucb_remote i_rem (.clk(clk), .tx_line(txo), .rx_line(rx));
    // compare and count
    task automatic chk(input logic [8:0] s, input logic [8:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("Error %0t: got %h want %h", $time, s, e);
        end
    endtask
    // bus cycles; a gap cycle keeps strobes from being set twice at once
    task automatic wrr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        ad <= a;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        ad <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // cycles until the line shows a level; a hang ends the run
    task automatic lvl(input logic l, output int c);
        for (c = 0; c < 9999 && txo !== l; c++)
            @(posedge clk);
        if (c == 9999) begin
            fail_count++;
            stop_test();
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // main sequence; divider 16, low byte first
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wrr(`UCB_OFF_BRDL, 8'h10);
        wrr(`UCB_OFF_BRDH, 8'h00);
        rdr(3'h7, 8'h00);
        // low seven bits of 35 hold four ones
        for (int p = 0; p < 4; p++) begin
            wrr(`UCB_OFF_LC1, 8'hA0 | 8'(p * 8));
            wrr(`UCB_OFF_LC2, 8'h80);
            wrr(`UCB_OFF_DATA, 8'h35);
            lvl(0, n);
            i_rem.recv(8, 16, w);
            chk(w[7:0], {p == 1 || p == 2, 7'h35});
            repeat (40) @(posedge clk);
        end
        wrr(`UCB_OFF_LC1, 8'hC1);
        wrr(`UCB_OFF_DATA, 8'h5A);
        lvl(0, n);
        i_rem.recv(9, 16, w);
        chk(w, 9'h15A);
        repeat (40) @(posedge clk);
        $display("format test done");
        // frame length per stop count and modulation, two words queued
        wrr(`UCB_OFF_LC1, 8'h80);
        for (int s = 0; s < 3; s++) begin
            wrr(`UCB_OFF_LC2, s == 1 ? 8'hA0 : 8'h80);
            wrr(`UCB_OFF_MODC, s == 2 ? 8'h18 : 8'h00);
            wrr(`UCB_OFF_DATA, 8'h00);
            wrr(`UCB_OFF_DATA, 8'hFF);
            lvl(0, n);
            lvl(1, n);
            lvl(0, m);
            chk(9'(n + m), 9'(s == 0 ? 161 : s == 1 ? 177 : 164));
            repeat (200) @(posedge clk);
        end
        // break: low 13 bit times, then high before anything else
        wrr(`UCB_OFF_LC1, 8'h84);
        lvl(0, n);
        repeat (208) @(posedge clk);
        chk(txo, 0);
        wrr(`UCB_OFF_LC1, 8'h80);
        lvl(1, n);
        chk(n < 18, 1);
        // abort mid-character, then port disable with empty request on
        wrr(`UCB_OFF_DATA, 8'h00);
        repeat (30) @(posedge clk);
        wrr(`UCB_OFF_LC2, 8'h01);
        #1 chk(oe, 0);
        wrr(`UCB_OFF_LC1, 8'h00);
        rdr(`UCB_OFF_STAT, 8'h0B);
        chk(irq, 1);
        rdr(`UCB_OFF_LC2, 8'h01);
        $display("transmit test done");
        // reception, nine-bit, then address filtering
        wrr(`UCB_OFF_LC1, 8'hC0);
        wrr(`UCB_OFF_LC2, 8'h44);
        i_rem.send(9'h1A5, 9, 16);
        chk(irq, 1);
        rdr(`UCB_OFF_LC1, 8'hC2);
        rdr(`UCB_OFF_DATA, 8'hA5);
        wrr(`UCB_OFF_LC1, 8'h80);
        wrr(`UCB_OFF_LC2, 8'h54);
        i_rem.send(9'h012, 8, 16);
        chk(irq, 0);
        i_rem.send(9'h092, 8, 16);
        chk(irq, 1);
        rdr(`UCB_OFF_DATA, 8'h92);
        wrr(`UCB_OFF_LC2, 8'h04);
        i_rem.send(9'h055, 8, 16);
        chk(irq, 0);
        // wake: none while clock runs or wake is off
        wrr(`UCB_OFF_LC2, 8'h48);
        i_rem.send(9'h0FF, 8, 16);
        chk(wake, 0);
        con <= 1'b0;
        wrr(`UCB_OFF_LC2, 8'h40);
        i_rem.send(9'h0FF, 8, 16);
        chk(wake, 0);
        wrr(`UCB_OFF_LC2, 8'h48);
        i_rem.send(9'h0FF, 8, 16);
        chk({wake, irq}, 9'h3);
        $display("receive test done");
        stop_test();
    end
endmodule
bind ucb_uart ucb_uart_chk i_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PORT_CLK_ON(PORT_CLK_ON), .TX_O(TX_O), .TX_OE(TX_OE),
    .IRQ_REQ(IRQ_REQ), .WAKE_REQ(WAKE_REQ));
